// *** fpg_flash_program_guard.v ***
// flash program guard: store control register, supply monitor gating, flash error reset
// ****************************************
// Summary of operation
// ****************************************
// Summary of operation
// R1: write or erase only with supply monitor and its reset source on; else error reset.
// R2: power-on reset sets supply monitor enable and its reset-source enable.
// R3: interrupts arriving during a flash operation stay pending until it ends.
// R4: control register bit 0 write enable, bit 1 erase enable; bits 7:2 read zero.
// R5: firmware keeps interrupts off while write enable is set.
// R6: firmware re-enables supply monitor inside each flash routine.
// R7: firmware writes reset-source register directly, power-on flag bit set.
// R8: firmware sets write enable for programming, both enables for page erase.
// R9: firmware runs from internal oscillator during flash operations.
// R10: key codes A5 then F1 arm one operation; wrong order locks until reset.
// R11: modification re-locks after every completed write or erase.
// R12: write with both enables erases whole 512-byte page to FF.
`timescale 1ns/1ps
`include "fpg_map.vh"
module fpg_flash_program_guard #(
   parameter ADDR_W = 14,
   parameter PAGE_BYTES = `FPG_PAGE_BYTES,
   parameter [7:0] OP_CYCLES = `FPG_OP_CYCLES
) (
   clk,
   rst_b,
   por_event,
   sfr_addr,
   sfr_wdata,
   sfr_wr,
   sfr_rd,
   sfr_rdata,
   xdata_wr,
   xdata_addr,
   xdata_wdata,
   irq_req,
   irq_pending,
   cpu_stall,
   flash_wr,
   flash_erase,
   flash_addr,
   flash_wdata,
   flash_error_reset,
   vmon_enable
);
   input wire clk;
   input wire rst_b;
   input wire por_event;
   input wire [7:0] sfr_addr;
   input wire [7:0] sfr_wdata;
   input wire sfr_wr;
   input wire sfr_rd;
   output reg [7:0] sfr_rdata;
   input wire xdata_wr;
   input wire [ADDR_W-1:0] xdata_addr;
   input wire [7:0] xdata_wdata;
   input wire irq_req;
   output wire irq_pending;
   output wire cpu_stall;
   output reg flash_wr;
   output reg flash_erase;
   output reg [ADDR_W-1:0] flash_addr;
   output reg [7:0] flash_wdata;
   output reg flash_error_reset;
   output wire vmon_enable;

   localparam PAGE_W = $clog2(PAGE_BYTES);

   // ****************************************
   // registers
   // ****************************************
   reg psc_we_r;
   reg psc_ee_r;
   reg vmon_en_r;
   reg vmon_rst_en_r;
   reg por_flag_r;
   reg ferr_flag_r;
   reg [7:0] busy_cnt_r;
   reg irq_hold_r;
   wire op_done;
   wire armed;
   wire locked;
   wire [1:0] key_state;
   wire key_wr;
   wire attempt;
   wire allowed;
   wire busy;

   assign key_wr = sfr_wr && (sfr_addr == `FPG_ADDR_KEY);
   assign attempt = xdata_wr && psc_we_r && !busy;
   assign busy = (busy_cnt_r != 8'h00);
   // relock on the last busy edge: a registered done would leave the keys armed
   // for the first idle cycle and let a second write through without re-keying
   assign op_done = busy && (busy_cnt_r == 8'h01); // R11
   assign allowed = armed && vmon_en_r && vmon_rst_en_r; // R1

   fpg_key_lock u_key (
      .clk(clk),
      .rst_b(rst_b),
      .key_wr(key_wr),
      .key_data(sfr_wdata),
      .op_done(op_done),
      .op_attempt(attempt && !armed),
      .armed(armed),
      .locked(locked),
      .key_state(key_state)
   );

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         psc_we_r <= 1'b0;
         psc_ee_r <= 1'b0;
         vmon_en_r <= 1'b1;
         vmon_rst_en_r <= 1'b1;
         por_flag_r <= 1'b1;
         ferr_flag_r <= 1'b0;
      end else begin
         if (por_event) begin
            vmon_en_r <= 1'b1; // R2
            vmon_rst_en_r <= 1'b1; // R2
            por_flag_r <= 1'b1;
         end else if (sfr_wr) begin
            case (sfr_addr)
               `FPG_ADDR_PSC: begin
                  psc_we_r <= sfr_wdata[`FPG_PSC_WE_BIT]; // R4
                  psc_ee_r <= sfr_wdata[`FPG_PSC_EE_BIT]; // R4
               end
               `FPG_ADDR_RSR: begin
                  vmon_rst_en_r <= sfr_wdata[`FPG_RSR_VMON_BIT];
               end
               `FPG_ADDR_VMC: begin
                  vmon_en_r <= sfr_wdata[`FPG_VMC_EN_BIT];
               end
               default: begin
               end
            endcase
         end
         // error flag is sticky across the error reset it causes
         if (attempt && !allowed) begin
            ferr_flag_r <= 1'b1; // R1
         end
      end
   end

   // ****************************************
   // flash operation sequencing
   // ****************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_cnt_r <= 8'h00;
         flash_wr <= 1'b0;
         flash_erase <= 1'b0;
         flash_addr <= {ADDR_W{1'b0}};
         flash_wdata <= 8'h00;
         flash_error_reset <= 1'b0;
      end else begin
         flash_wr <= 1'b0;
         flash_erase <= 1'b0;
         flash_error_reset <= attempt && !allowed; // R1
         if (attempt && allowed) begin
            busy_cnt_r <= OP_CYCLES;
            if (psc_ee_r) begin
               flash_erase <= 1'b1; // R12
               flash_addr <= {xdata_addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}}; // R12
               flash_wdata <= `FPG_ERASE_VAL; // R12
            end else begin
               flash_wr <= 1'b1;
               flash_addr <= xdata_addr;
               flash_wdata <= xdata_wdata;
            end
         end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - 8'h01;
         end
      end
   end

   // interrupts seen while busy are held and released once the operation ends
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_hold_r <= 1'b0;
      end else if (irq_req && busy) begin
         irq_hold_r <= 1'b1; // R3
      end else if (!busy) begin
         irq_hold_r <= 1'b0;
      end
   end

   assign cpu_stall = busy;
   assign irq_pending = !busy && (irq_req || irq_hold_r); // R3
   assign vmon_enable = vmon_en_r;

   always @* begin
      sfr_rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            `FPG_ADDR_PSC: sfr_rdata = {6'b000000, psc_ee_r, psc_we_r}; // R4
            `FPG_ADDR_RSR: sfr_rdata = {1'b0, ferr_flag_r, 4'h0, vmon_rst_en_r, por_flag_r};
            `FPG_ADDR_VMC: sfr_rdata = {vmon_en_r, 7'h00};
            `FPG_ADDR_KEY: sfr_rdata = {4'h0, locked, armed, key_state};
            default: sfr_rdata = 8'h00;
         endcase
      end
   end
endmodule // fpg_flash_program_guard

// *** fpg_map.vh ***
// register addresses, field positions, key codes and timing counts for the flash program guard
`ifndef FPG_MAP_VH
`define FPG_MAP_VH
`define FPG_ADDR_PSC 8'h8F
`define FPG_ADDR_KEY 8'hB7
`define FPG_ADDR_RSR 8'hEF
`define FPG_ADDR_VMC 8'hFF
`define FPG_PSC_WE_BIT 0
`define FPG_PSC_EE_BIT 1
`define FPG_PSC_RESET 8'h00
`define FPG_KEY_FIRST 8'hA5
`define FPG_KEY_SECOND 8'hF1
`define FPG_RSR_POR_BIT 1
`define FPG_RSR_VMON_BIT 1
`define FPG_RSR_FERR_BIT 6
`define FPG_VMC_EN_BIT 7
`define FPG_PAGE_BYTES 512
`define FPG_ERASE_VAL 8'hFF
`define FPG_OP_CYCLES 8'h04
`endif

// *** fpg_key_lock.v ***
// flash key sequence tracker: arms modification after the two key codes, locks on error
`timescale 1ns/1ps
`include "fpg_map.vh"
module fpg_key_lock (
   clk,
   rst_b,
   key_wr,
   key_data,
   op_done,
   op_attempt,
   armed,
   locked,
   key_state
);
   input wire clk;
   input wire rst_b;
   input wire key_wr;
   input wire [7:0] key_data;
   input wire op_done;
   input wire op_attempt;
   output wire armed;
   output wire locked;
   output wire [1:0] key_state;

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_HALF = 2'b01;
   localparam [1:0] ST_ARMED = 2'b10;
   localparam [1:0] ST_LOCK = 2'b11;

   reg [1:0] state_r;
   reg [1:0] state_nxt;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (op_attempt) begin
               state_nxt = ST_LOCK; // R10
            end else if (key_wr) begin
               state_nxt = (key_data == `FPG_KEY_FIRST) ? ST_HALF : ST_LOCK; // R10
            end
         end
         ST_HALF: begin
            if (op_attempt) begin
               state_nxt = ST_LOCK;
            end else if (key_wr) begin
               state_nxt = (key_data == `FPG_KEY_SECOND) ? ST_ARMED : ST_LOCK; // R10
            end
         end
         ST_ARMED: begin
            // a further key write while armed counts as out of order
            if (key_wr) begin
               state_nxt = ST_LOCK;
            end else if (op_done) begin
               state_nxt = ST_IDLE; // R11
            end
         end
         ST_LOCK: state_nxt = ST_LOCK;
         default: state_nxt = ST_LOCK;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign armed = (state_r == ST_ARMED);
   assign locked = (state_r == ST_LOCK);
   assign key_state = state_r;
endmodule // fpg_key_lock

// *** fpg_guard_chk.sv ***
// port checker for the flash program guard
`timescale 1ns/1ps
`include "fpg_map.vh"
module fpg_guard_chk #(parameter ADDR_W = 14) (
   input logic clk,
   input logic rst_b,
   input logic por_event,
   input logic [7:0] sfr_addr,
   input logic sfr_rd,
   input logic [7:0] sfr_rdata,
   input logic xdata_wr,
   input logic irq_req,
   input logic irq_pending,
   input logic cpu_stall,
   input logic flash_wr,
   input logic flash_erase,
   input logic [ADDR_W-1:0] flash_addr,
   input logic [7:0] flash_wdata,
   input logic flash_error_reset,
   input logic vmon_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_op;
      flash_wr || flash_erase;
   endsequence
   chk_op_cause: assert property (s_op |-> $past(xdata_wr))
      else $error("flash op without data write");
   chk_no_mix: assert property (!(flash_error_reset && (flash_wr || flash_erase)))
      else $error("op and error reset together");
   chk_erase_page: assert property (flash_erase |-> flash_addr[8:0] == 9'h000 && flash_wdata == 8'hFF)
      else $error("erase not page aligned to FF");
   chk_irq_held: assert property (cpu_stall |-> !irq_pending)
      else $error("interrupt released while busy");
   chk_irq_pass: assert property (!cpu_stall && irq_req |-> irq_pending)
      else $error("interrupt kept while idle");
   chk_por_mon: assert property (por_event |=> vmon_enable)
      else $error("monitor not enabled after power on");
   chk_psc_read: assert property (sfr_rd && sfr_addr == `FPG_ADDR_PSC |-> sfr_rdata[7:2] == 6'h00)
      else $error("control upper bits not zero");
   chk_single_op: assert property (s_op |=> !(flash_wr || flash_erase) [*4])
      else $error("second op without new keys");
endmodule // fpg_guard_chk
bind fpg_flash_program_guard fpg_guard_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .rst_b(rst_b),
   .por_event(por_event), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
   .xdata_wr(xdata_wr), .irq_req(irq_req), .irq_pending(irq_pending), .cpu_stall(cpu_stall),
   .flash_wr(flash_wr), .flash_erase(flash_erase), .flash_addr(flash_addr),
   .flash_wdata(flash_wdata), .flash_error_reset(flash_error_reset),
   .vmon_enable(vmon_enable));

// *** fpg_flash_program_guard_tb_top.sv ***
// scenario testbench for the flash program guard
`timescale 1ns/1ps
`include "fpg_map.vh"
module fpg_flash_program_guard_tb_top;
   reg clk = 0, rst_b = 0, por_event = 0, sfr_wr = 0, sfr_rd = 0, xdata_wr = 0, irq_req = 0;
   reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, xdata_wdata = 8'h00;
   reg [13:0] xdata_addr = 14'h0000;
   wire [7:0] sfr_rdata, flash_wdata;
   wire [13:0] flash_addr;
   wire irq_pending, cpu_stall, flash_wr, flash_erase, flash_error_reset, vmon_enable;
   reg [3:0] k;
   reg [13:0] fa;
   reg [7:0] fd;
   integer errors = 0;
   integer samples_checked = 0;
   fpg_flash_program_guard dut_u (.clk(clk), .rst_b(rst_b), .por_event(por_event),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
      .xdata_wdata(xdata_wdata), .irq_req(irq_req), .irq_pending(irq_pending),
      .cpu_stall(cpu_stall), .flash_wr(flash_wr), .flash_erase(flash_erase),
      .flash_addr(flash_addr), .flash_wdata(flash_wdata),
      .flash_error_reset(flash_error_reset), .vmon_enable(vmon_enable));
   // one clock for the whole run, so no flash operation ever sees a second oscillator
   initial forever #20 clk = ~clk;
   // ****************************************
   // shared tasks
   // ****************************************
   task conclude; begin
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   end endtask
   task cmp(input [31:0] got, input [31:0] exp); begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   end endtask
   task rst; begin
      @(negedge clk); rst_b = 0; repeat (3) @(negedge clk); rst_b = 1;
   end endtask
   task sw(input [7:0] a, input [7:0] d); begin
      @(negedge clk); sfr_addr = a; sfr_wdata = d; sfr_wr = 1;
      @(negedge clk); sfr_wr = 0;
   end endtask
   task sr(input [7:0] a, input [7:0] m, input [7:0] e); begin
      @(negedge clk); sfr_addr = a; sfr_rd = 1;
      @(negedge clk); cmp(sfr_rdata & m, e); sfr_rd = 0;
   end endtask
   task keys; begin
      sw(`FPG_ADDR_KEY, `FPG_KEY_FIRST); sw(`FPG_ADDR_KEY, `FPG_KEY_SECOND);
   end endtask
   // k holds {irq_pending, error reset, erase, write} of the first answer seen;
   // q raises the interrupt request for one cycle while the operation is busy
   task op(input [13:0] a, input [7:0] d, input q);
      integer i;
      begin
      k = 0; fa = 0; fd = 0;
      @(negedge clk); xdata_addr = a; xdata_wdata = d; xdata_wr = 1;
      @(negedge clk); xdata_wr = 0;
      for (i = 0; i < 4; i = i + 1) begin
         if (k == 0 && (flash_wr | flash_erase | flash_error_reset)) begin
            k = {irq_pending, flash_error_reset, flash_erase, flash_wr};
            fa = flash_addr;
            fd = flash_wdata;
         end
         irq_req = (i == 0) ? q : 1'b0;
         @(negedge clk);
      end
   end endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_regs; begin
      sr(`FPG_ADDR_PSC, 8'hFF, 8'h00);
      cmp(vmon_enable, 1);
      sw(`FPG_ADDR_PSC, 8'hFF); sr(`FPG_ADDR_PSC, 8'hFF, 8'h03);
   end endtask
   task t_erase; begin
      keys; op(14'h0345, 8'h12, 1'b1);
      cmp(k, 4'h2);
      cmp({fa, fd}, {14'h0200, 8'hFF});
      cmp(irq_pending, 1);
      // second attempt on the second idle cycle, with no new keys
      op(14'h0345, 8'h12, 1'b0); cmp(k[2:0], 3'h4);
      cmp(irq_pending, 0);
   end endtask
   task t_write; begin
      sw(`FPG_ADDR_PSC, 8'h01);
      sw(`FPG_ADDR_RSR, 8'h02);
      sw(`FPG_ADDR_VMC, 8'h80);
      keys; op(14'h0123, 8'h5A, 1'b0);
      cmp({k[2:0], fa, fd}, {3'h1, 14'h0123, 8'h5A});
      sw(`FPG_ADDR_PSC, 8'h00);
   end endtask
   task t_nomon; begin
      sw(`FPG_ADDR_PSC, 8'h01); sw(`FPG_ADDR_VMC, 8'h00); keys; op(14'h0010, 8'h00, 1'b0);
      cmp(k[2:0], 3'h4);
      sr(`FPG_ADDR_RSR, 8'h40, 8'h40);
      @(negedge clk); por_event = 1; @(negedge clk); por_event = 0;
      cmp(vmon_enable, 1);
      // monitor on but not a reset source: still refused
      sw(`FPG_ADDR_RSR, 8'h00); op(14'h0010, 8'h00, 1'b0);
      cmp(k[2:0], 3'h4);
   end endtask
   task t_badkey; begin
      sw(`FPG_ADDR_PSC, 8'h01); sw(`FPG_ADDR_KEY, `FPG_KEY_SECOND); keys; op(14'h0020, 8'h00, 1'b0);
      cmp(k[2:0], 3'h4);
   end endtask
   initial begin
      rst; t_regs; t_erase;
      rst; t_write; t_write;
      rst; t_nomon;
      rst; t_badkey;
      conclude;
   end
   initial begin
      #200000; errors = errors + 1; conclude;
   end
endmodule // fpg_flash_program_guard_tb_top
